/* rtl/gpb_pkg.sv */
// Purpose: Shared constants for the general-purpose port bank
// Assumes: Nine ports of eight pins each (port G has five), indexed A=0 through J=8
// Notes:   Register kinds select which of a port's three registers is hit
package gpb_pkg;

   // ********************************************************************
   // Geometry
   // ********************************************************************
   localparam int GPB_NPORT = 9;
   localparam int GPB_NPIN  = 8;

   // Port indices
   localparam logic [3:0] GPB_PORT_B = 4'h1;
   localparam logic [3:0] GPB_PORT_C = 4'h2;
   localparam logic [3:0] GPB_PORT_D = 4'h3;
   localparam logic [3:0] GPB_PORT_E = 4'h4;
   localparam logic [3:0] GPB_PORT_G = 4'h6;
   localparam logic [3:0] GPB_PORT_J = 4'h8;
   localparam int         GPB_G_PINS = 5;

   // ********************************************************************
   // Register kinds and reset values
   // ********************************************************************
   localparam logic [1:0] GPB_KIND_DIR = 2'h0;
   localparam logic [1:0] GPB_KIND_PIN = 2'h1;
   localparam logic [1:0] GPB_KIND_LAT = 2'h2;
   localparam logic [7:0] GPB_DIR_RST  = 8'hFF;
   localparam logic [7:0] GPB_LAT_RST  = 8'h00;
   localparam logic [2:0] GPB_PU_RST   = 3'h0;

   // ********************************************************************
   // Port G upper-bit fields
   // ********************************************************************
   // Pin register <7:5>: pull-up enables for D, E, J (high to low)
   localparam int GPB_PU_LSB = 5;
   localparam int GPB_PU_D   = 2;
   localparam int GPB_PU_E   = 1;
   localparam int GPB_PU_J   = 0;
   // Open-drain units: dir <7:5> gives units 0-2, latch <7:5> units 3-5
   localparam int GPB_OD_LSB   = 5;
   localparam int GPB_OD_UNITS = 6;
   // Unit order: serial0, serial1, sync serial, capture/compare 0-2
   // Each unit has two entries {port[3:0], pin[2:0]}: data, clock; capture/compare units repeat one pin
   localparam logic [11:0][6:0] GPB_OD_LOC = {
      7'h34, 7'h34,   // capture/compare 2 on G4 (single output)
      7'h27, 7'h27,   // capture/compare 1 on E7
      7'h12, 7'h12,   // capture/compare 0 on C2
      7'h15, 7'h13,   // sync serial: data C5, clock C3
      7'h31, 7'h32,   // serial1: data G1, clock G2
      7'h16, 7'h17    // serial0: data C6, clock C7
   };

endpackage

/* rtl/gpb_port_bank.sv */
// Purpose: Nine-port GPIO bank: direction, pin level and output latch
// Assumes: Single sys_clk domain; pins sampled asynchronously
// Notes:   Pull-ups are enable signals for the pad ring; open-drain gates pin_oe and pin_out
//
// Functional notes
// RULE_01 - Nine ports, three registers each
// RULE_02 - Pin register reads sampled pin levels
// RULE_03 - Pin register write lands in latch
// RULE_04 - Direction one releases pin driver
// RULE_05 - Direction zero drives latch onto pin
// RULE_06 - Latch read returns latched drive values
// RULE_07 - Enabled peripheral takes over its pin
// RULE_08 - Ports B, D, E, J: per-port pull-ups
// RULE_09 - Port B pull-up from interrupt control bit 7
// RULE_10 - D, E, J pull-ups in G pin bits 7:5
// RULE_11 - Open-drain bits in G direction and latch
// RULE_12 - Board supplies external pull-up, 5 V max
// RULE_13 - Pin inputs synchronised before use
// RULE_14 - Open-drain drives low, releases for high
`timescale 1ns/1ns
`default_nettype none

module gpb_port_bank
   import gpb_pkg::*;
(
   // Clock and reset
   input  wire logic                                   sys_clk,
   input  wire logic                                   reset,
   // Register write port
   input  wire logic                                   wr_en,
   input  wire logic [3:0]                             wr_port,
   input  wire logic [1:0]                             wr_kind,
   input  wire logic [7:0]                             wr_data,
   // Register read port
   input  wire logic                                   rd_en,
   input  wire logic [3:0]                             rd_port,
   input  wire logic [1:0]                             rd_kind,
   output logic [7:0]                                  rd_data,
   output logic                                        rd_valid,
   // Pull-up enable held in interrupt_control_second<7>
   input  wire logic                                   port_b_pullup_en,
   // Peripheral overrides per pin
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0]     periph_en,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0]     periph_out,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0]     periph_oe,
   // Pads
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0]     pin_in,
   output logic      [gpb_pkg::GPB_NPORT-1:0][7:0]     pin_out,
   output logic      [gpb_pkg::GPB_NPORT-1:0][7:0]     pin_oe,
   output logic      [gpb_pkg::GPB_NPORT-1:0][7:0]     pullup_on,
   output logic      [gpb_pkg::GPB_NPORT-1:0][7:0]     pin_level
);
   import gpb_pkg::*;

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic [GPB_NPORT-1:0][7:0] dir;
      logic [GPB_NPORT-1:0][7:0] lat;
      logic [2:0]                pu_dej;
      logic [GPB_NPORT-1:0][7:0] s1;
      logic [GPB_NPORT-1:0][7:0] s2;
      logic [GPB_NPORT-1:0][7:0] s3;
      logic [GPB_NPORT-1:0][7:0] lvl;
      logic [7:0]                rdat;
      logic                      rvld;
      logic [GPB_NPORT-1:0][7:0] pout;
      logic [GPB_NPORT-1:0][7:0] poe;
      logic [GPB_NPORT-1:0][7:0] pu;
   } gpb_state_t;

   gpb_state_t state_ff;
   gpb_state_t nxt_state;

   logic [GPB_NPORT-1:0][7:0] od_mask;
   logic [GPB_OD_UNITS-1:0]   od_en;
   logic [GPB_NPORT-1:0]      port_pu;
   logic [GPB_NPORT-1:0][7:0] pin_exists;

   // ********************************************************************
   // Open-drain and pull-up selection
   // ********************************************************************
   always_comb begin
      od_en = {state_ff.lat[GPB_PORT_G][7:GPB_OD_LSB],
               state_ff.dir[GPB_PORT_G][7:GPB_OD_LSB]}; // RULE_11
      od_mask = '0;
      for (int u = 0; u < GPB_OD_UNITS; u++) begin
         for (int k = 0; k < 2; k++) begin
            if (od_en[u]) begin
               od_mask[GPB_OD_LOC[2*u+k][6:3]][GPB_OD_LOC[2*u+k][2:0]]
                  = 1'b1; // RULE_11
            end
         end
      end
      port_pu             = '0;
      port_pu[GPB_PORT_B] = port_b_pullup_en; // RULE_09
      port_pu[GPB_PORT_D] = state_ff.pu_dej[GPB_PU_D]; // RULE_10
      port_pu[GPB_PORT_E] = state_ff.pu_dej[GPB_PU_E]; // RULE_10
      port_pu[GPB_PORT_J] = state_ff.pu_dej[GPB_PU_J]; // RULE_10
      pin_exists = '1;
      // Port G has only its low pins; upper bits are control fields
      pin_exists[GPB_PORT_G][7:GPB_G_PINS] = '0;
   end

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      logic drv;
      logic val;
      drv       = 1'b0;
      val       = 1'b0;
      nxt_state = state_ff;

      // Three-stage sampling; level moves only when stages 2, 3 agree
      nxt_state.s1 = pin_in; // RULE_13
      nxt_state.s2 = state_ff.s1; // RULE_13
      nxt_state.s3 = state_ff.s2; // RULE_13
      for (int p = 0; p < GPB_NPORT; p++) begin
         for (int b = 0; b < GPB_NPIN; b++) begin
            if (state_ff.s2[p][b] == state_ff.s3[p][b]) begin
               nxt_state.lvl[p][b] = state_ff.s3[p][b]; // RULE_13
            end
         end
      end

      // Writes: pin register and latch both land in the latch; G pin bits 7:5 go to pu_dej
      if (wr_en && wr_port < 4'(GPB_NPORT)) begin // RULE_01
         case (wr_kind)
            GPB_KIND_DIR: begin
               nxt_state.dir[wr_port] = wr_data;
            end
            GPB_KIND_PIN: begin
               if (wr_port == GPB_PORT_G) begin
                  nxt_state.lat[wr_port][GPB_G_PINS-1:0] =
                     wr_data[GPB_G_PINS-1:0]; // RULE_03
                  nxt_state.pu_dej = wr_data[7:GPB_PU_LSB]; // RULE_10
               end else begin
                  nxt_state.lat[wr_port] = wr_data; // RULE_03
               end
            end
            GPB_KIND_LAT: begin
               nxt_state.lat[wr_port] = wr_data;
            end
            default: begin
            end
         endcase
      end

      // Reads are answered the next cycle from pre-write state
      nxt_state.rvld = rd_en;
      nxt_state.rdat = '0;
      if (rd_en && rd_port < 4'(GPB_NPORT)) begin // RULE_01
         case (rd_kind)
            GPB_KIND_DIR: nxt_state.rdat = state_ff.dir[rd_port];
            GPB_KIND_PIN: begin
               nxt_state.rdat = state_ff.lvl[rd_port]; // RULE_02
               if (rd_port == GPB_PORT_G) begin
                  nxt_state.rdat[7:GPB_PU_LSB] = state_ff.pu_dej;
               end
            end
            GPB_KIND_LAT: nxt_state.rdat = state_ff.lat[rd_port]; // RULE_06
            default:      nxt_state.rdat = '0;
         endcase
      end

      // Pad drive follows new dir and lat values in the same edge; G open-drain and pull-up bits act one edge later
      for (int p = 0; p < GPB_NPORT; p++) begin
         for (int b = 0; b < GPB_NPIN; b++) begin
            if (periph_en[p][b]) begin
               drv = periph_oe[p][b]; // RULE_07
               val = periph_out[p][b]; // RULE_07
            end else begin
               drv = ~nxt_state.dir[p][b]; // RULE_04
               val = nxt_state.lat[p][b]; // RULE_05
            end
            drv = drv & pin_exists[p][b];
            if (od_mask[p][b]) begin
               // Only sink current; the board pulls high
               nxt_state.poe[p][b]  = drv & ~val; // RULE_14
               nxt_state.pout[p][b] = 1'b0; // RULE_14
            end else begin
               nxt_state.poe[p][b]  = drv;
               nxt_state.pout[p][b] = val;
            end
            // Weak pull-up only while the pin is not driven
            nxt_state.pu[p][b] = port_pu[p] & ~drv &
                                 pin_exists[p][b]; // RULE_08
         end
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_ff        <= '0;
         state_ff.dir    <= {GPB_NPORT{GPB_DIR_RST}};
         state_ff.lat    <= {GPB_NPORT{GPB_LAT_RST}};
         state_ff.pu_dej <= GPB_PU_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign rd_data   = state_ff.rdat;
   assign rd_valid  = state_ff.rvld;
   assign pin_out   = state_ff.pout;
   assign pin_oe    = state_ff.poe;
   assign pullup_on = state_ff.pu;
   assign pin_level = state_ff.lvl;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_pin_write_to_lat;
      wr_en && wr_kind == GPB_KIND_PIN && wr_port == GPB_PORT_B
      |=> state_ff.lat[GPB_PORT_B] == $past(wr_data);
   endproperty
   a_pin_write_to_lat: assert property (p_pin_write_to_lat) // RULE_03
      else $error("pin register write did not reach latch");

   property p_lat_read;
      rd_en && rd_kind == GPB_KIND_LAT && rd_port == GPB_PORT_C
      |=> rd_valid && rd_data == $past(state_ff.lat[GPB_PORT_C]);
   endproperty
   a_lat_read: assert property (p_lat_read) // RULE_06
      else $error("latch read returned wrong value");

   property p_pin_read;
      rd_en && rd_kind == GPB_KIND_PIN && rd_port == GPB_PORT_D
      |=> rd_data == $past(state_ff.lvl[GPB_PORT_D]);
   endproperty
   a_pin_read: assert property (p_pin_read) // RULE_02
      else $error("pin read did not return sampled level");

   property p_input_hiz;
      !$past(periph_en[GPB_PORT_B][0]) && state_ff.dir[GPB_PORT_B][0]
      && !$past(reset) && $stable(state_ff.dir[GPB_PORT_B][0])
      |-> !pin_oe[GPB_PORT_B][0];
   endproperty
   a_input_hiz: assert property (p_input_hiz) // RULE_04
      else $error("input pin is being driven");

   localparam int GPB_PORT_A0 = 0;
   property p_output_drive;
      !periph_en[GPB_PORT_A0][0] ##1 !state_ff.dir[0][0]
      |-> pin_oe[0][0] && pin_out[0][0] == state_ff.lat[0][0];
   endproperty
   a_output_drive: assert property (p_output_drive) // RULE_05
      else $error("output pin does not follow latch");

   property p_periph_take;
      periph_en[GPB_PORT_C][6] && !od_mask[GPB_PORT_C][6] |=>
         pin_oe[GPB_PORT_C][6] == $past(periph_oe[GPB_PORT_C][6])
         && pin_out[GPB_PORT_C][6] == $past(periph_out[GPB_PORT_C][6]);
   endproperty
   a_periph_take: assert property (p_periph_take) // RULE_07
      else $error("peripheral does not control its pin");

   property p_pullup_b;
      port_b_pullup_en && !periph_en[GPB_PORT_B][5]
      && !nxt_state.dir[GPB_PORT_B][5] == 1'b0
      |=> pullup_on[GPB_PORT_B][5];
   endproperty
   a_pullup_b: assert property (p_pullup_b) // RULE_09
      else $error("port B pull-up not applied");

   property p_pullup_d;
      pullup_on[GPB_PORT_D][2] |-> $past(state_ff.pu_dej[GPB_PU_D]);
   endproperty
   a_pullup_d: assert property (p_pullup_d) // RULE_10
      else $error("port D pull-up without enable");

   property p_no_pullup_c;
      pullup_on[GPB_PORT_C] == '0;
   endproperty
   a_no_pullup_c: assert property (p_no_pullup_c) // RULE_08
      else $error("pull-up on a port without pull-ups");

   property p_od_never_high;
      od_mask[GPB_PORT_C][6] && $stable(od_mask[GPB_PORT_C][6])
      && pin_oe[GPB_PORT_C][6] |-> !pin_out[GPB_PORT_C][6];
   endproperty
   a_od_never_high: assert property (p_od_never_high) // RULE_14
      else $error("open-drain pin driven high");

   property p_sync_delay;
      $changed(pin_level[GPB_PORT_E][1])
      |-> $past(pin_in[GPB_PORT_E][1], 3) == pin_level[GPB_PORT_E][1];
   endproperty
   a_sync_delay: assert property (p_sync_delay) // RULE_13
      else $error("pin level changed without synchroniser delay");

   c_pin_write: cover property (wr_en && wr_kind == GPB_KIND_PIN
                                ##1 rd_en && rd_kind == GPB_KIND_LAT);
   c_od_low:    cover property (od_mask[GPB_PORT_C][6]
                                && pin_oe[GPB_PORT_C][6]);
   c_pullup_j:  cover property (pullup_on[GPB_PORT_J][0]);

endmodule

`default_nettype wire

/* bench/gpb_board.sv */
// Purpose: Board model that resolves every pad of the port bank
// Assumes: External pull-ups and test drivers are set by the bench
// Notes:   Floating pads toggle each cycle so no stale level survives
`timescale 1ns/1ns
`default_nettype none

module gpb_board
   import gpb_pkg::*;
(
   // Clock
   input  wire logic                                sys_clk,
   // Device pad side
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] pin_out,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] pin_oe,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] pullup_on,
   output logic      [gpb_pkg::GPB_NPORT-1:0][7:0] pin_in,
   // Test drivers
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] ext_en,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] ext_val,
   input  wire logic [gpb_pkg::GPB_NPORT-1:0][7:0] ext_pu
);
   // ****************
   // Pad resolution
   // ****************
   logic [7:0] noise_ff = 8'h5A;

   always_ff @(posedge sys_clk) begin
      noise_ff <= ~noise_ff;
   end

   always_comb begin
      for (int i = 0; i < GPB_NPORT; i++) begin
         for (int b = 0; b < 8; b++) begin
            pin_in[i][b] = pin_oe[i][b] ? pin_out[i][b] :
               ext_en[i][b] ? ext_val[i][b] :
               (pullup_on[i][b] | ext_pu[i][b]) ? 1'b1 :
               noise_ff[b];
         end
      end
   end
endmodule

`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the port bank
// Assumes: Read answers come exactly one cycle after the strobe
// Notes:   Random writes skip port G so its control bits stay known
`timescale 1ns/1ns
`default_nettype none

module tb;
   import gpb_pkg::*;
   typedef logic [GPB_NPORT-1:0][7:0] gpb_bank_t;

   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic       wr_en = 1'b0, rd_en = 1'b0, pb_pu = 1'b0, rd_valid;
   logic [3:0] wr_port = '0, rd_port = '0, up;
   logic [1:0] wr_kind = '0, rd_kind = '0, uk;
   logic [7:0] wr_data = '0, rd_data, d;
   logic [2:0] pu_s, ub, un;
   gpb_bank_t  p_en = '0, p_out = '0, p_oe = '0, x_en = '0, x_val = '0;
   gpb_bank_t  x_pu = '0, pin_in, pin_out, pin_oe, pu_on, lvl, e;
   logic [7:0] dir_s [GPB_NPORT];
   logic [7:0] lat_s [GPB_NPORT];
   int         failures = 0;
   int         samples_checked = 0;
   integer     seed = 69912;
   int         p, k;
   // Open-drain units: {kind, enable bit, port, pin}
   localparam logic [11:0] OD_TAB [4] = '{{2'h0, 3'h5, 4'h2, 3'h6},
      {2'h0, 3'h7, 4'h2, 3'h5}, {2'h2, 3'h5, 4'h2, 3'h2},
      {2'h2, 3'h6, 4'h4, 3'h7}};

   always #5 sys_clk = ~sys_clk;

   gpb_port_bank u_dut (
      .sys_clk(sys_clk), .reset(reset), .wr_en(wr_en), .wr_port(wr_port),
      .wr_kind(wr_kind), .wr_data(wr_data), .rd_en(rd_en),
      .rd_port(rd_port), .rd_kind(rd_kind), .rd_data(rd_data),
      .rd_valid(rd_valid), .port_b_pullup_en(pb_pu), .periph_en(p_en),
      .periph_out(p_out), .periph_oe(p_oe), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu_on),
      .pin_level(lvl));

   gpb_board u_board (
      .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pu_on), .pin_in(pin_in), .ext_en(x_en),
      .ext_val(x_val), .ext_pu(x_pu));

   // ****************
   // Helpers
   // ****************
   task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s exp %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkb(string what, gpb_bank_t exp, gpb_bank_t got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s exp %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(logic [3:0] pt, logic [1:0] kd, logic [7:0] dt);
      @(negedge sys_clk);
      wr_en = 1'b1;
      wr_port = pt;
      wr_kind = kd;
      wr_data = dt;
      @(negedge sys_clk);
      wr_en = 1'b0;
   endtask

   task automatic rd(logic [3:0] pt, logic [1:0] kd, output logic [7:0] dt);
      @(negedge sys_clk);
      rd_en = 1'b1;
      rd_port = pt;
      rd_kind = kd;
      @(negedge sys_clk);
      rd_en = 1'b0;
      chk8("rd_valid", 8'h01, 8'(rd_valid));
      dt = rd_data;
   endtask

   // Sel 0 drive enables, 1 driven values, 2 pull-ups; no peripherals
   function automatic gpb_bank_t exp_bank(int sel);
      gpb_bank_t oe, r;
      for (int i = 0; i < GPB_NPORT; i++) begin
         oe[i] = ~dir_s[i] & ((4'(i) == GPB_PORT_G) ? 8'h1F : 8'hFF);
         r[i] = (sel == 1) ? (lat_s[i] & oe[i]) : oe[i];
      end
      if (sel == 2) begin
         r = '0;
         r[GPB_PORT_B] = {8{pb_pu}} & ~oe[GPB_PORT_B];
         r[GPB_PORT_D] = {8{pu_s[GPB_PU_D]}} & ~oe[GPB_PORT_D];
         r[GPB_PORT_E] = {8{pu_s[GPB_PU_E]}} & ~oe[GPB_PORT_E];
         r[GPB_PORT_J] = {8{pu_s[GPB_PU_J]}} & ~oe[GPB_PORT_J];
      end
      return r;
   endfunction

   task automatic check_pads();
      repeat (2) @(negedge sys_clk);
      e = exp_bank(0);
      chkb("pin_oe", e, pin_oe);
      chkb("pin_out", exp_bank(1), pin_out & e);
      chkb("pullup_on", exp_bank(2), pu_on);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      for (int i = 0; i < GPB_NPORT; i++) begin
         dir_s[i] = 8'hFF;
         lat_s[i] = 8'h00;
      end
      pu_s = 3'h0;
      repeat (20) @(negedge sys_clk);
      reset = 1'b0;
      // Reset values; unmapped port or kind reads zero
      for (int i = 0; i < 10; i++) begin
         for (int j = 0; j < 4; j++) begin
            if (j != 1) begin
               rd(4'(i), 2'(j), d);
               chk8("reset rd", {8{i < 9 && j == 0}}, d);
            end
         end
      end
      check_pads();
      // Open-drain off so port C and G pins act as plain GPIO
      wr(GPB_PORT_G, GPB_KIND_DIR, 8'h1F);
      dir_s[GPB_PORT_G] = 8'h1F;
      // Pin-register write to a plain port lands in its latch
      wr(GPB_PORT_B, GPB_KIND_PIN, 8'hA5);
      lat_s[GPB_PORT_B] = 8'hA5;
      rd(GPB_PORT_B, GPB_KIND_LAT, d);
      chk8("b latch", 8'hA5, d);
      // Random writes, port G replaced by an unmapped port
      repeat (60) begin
         p = {$random(seed)} % 10;
         k = {$random(seed)} % 4;
         d = 8'($random(seed));
         pb_pu = 1'($random(seed));
         if (p == 6) p = 9;
         wr(4'(p), 2'(k), d);
         if (p < 9 && k == 0) dir_s[p] = d;
         if (p < 9 && (k == 1 || k == 2)) lat_s[p] = d;
         check_pads();
         rd(4'(p % 9), GPB_KIND_LAT, d);
         chk8("latch rd", lat_s[p % 9], d);
      end
      // Pin reads see the pads, after the synchroniser delay
      for (int i = 0; i < GPB_NPORT; i++) begin
         wr(4'(i), GPB_KIND_DIR, 8'hFF);
         dir_s[i] = 8'hFF;
         x_en[i] = 8'hFF;
         x_val[i] = lat_s[i];
         d = (i == 6) ? 8'h1F : 8'hFF;
         repeat (6) @(negedge sys_clk);
         x_val[i] = ~lat_s[i];
         repeat (2) @(negedge sys_clk);
         chk8("pin_level lag", lat_s[i] & d, lvl[i] & d);
         repeat (4) @(negedge sys_clk);
         chk8("pin_level", ~lat_s[i] & d, lvl[i] & d);
         rd(4'(i), GPB_KIND_PIN, e[0]);
         chk8("pin rd", ~lat_s[i] & d, e[0] & d);
         x_en[i] = 8'h00;
      end
      // All eight D, E, J pull-up enable combinations, port B following J
      for (int v = 0; v < 8; v++) begin
         pb_pu = v[0];
         pu_s = 3'(v);
         wr(GPB_PORT_G, GPB_KIND_PIN, {3'(v), 5'h00});
         check_pads();
         rd(GPB_PORT_G, GPB_KIND_PIN, d);
         chk8("g pull-up bits", {3'(v), 5'h00}, d & 8'hE0);
         rd(GPB_PORT_G, GPB_KIND_LAT, d);
         chk8("g latch", 8'h00, d);
      end
      // Peripheral ownership, plain then open-drain, low and high
      for (int u = 0; u < 4; u++) begin
         {uk, ub, up, un} = OD_TAB[u];
         wr(GPB_PORT_G, GPB_KIND_DIR, 8'h1F);
         wr(GPB_PORT_G, GPB_KIND_LAT, 8'h00);
         p_en[up][un] = 1'b1;
         p_oe[up][un] = 1'b1;
         x_pu[up][un] = 1'b1;
         for (int s = 0; s < 4; s++) begin
            if (s == 2) wr(GPB_PORT_G, uk, (uk == GPB_KIND_DIR ?
               8'h1F : 8'h00) | (8'h01 << ub));
            p_out[up][un] = s[0];
            repeat (6) @(negedge sys_clk);
            chk8("od oe", 8'(s != 3), 8'(pin_oe[up][un]));
            chk8("od out", 8'(s == 1), 8'(pin_out[up][un]));
            chk8("od level", 8'(s[0]), 8'(lvl[up][un]));
         end
         p_en[up][un] = 1'b0;
      end
      close_out();
   end
endmodule

`default_nettype wire
